// >>> shared/dmamm_pkg.sv
// Purpose: Shared constants and types for the memory-to-memory DMA channel.
// Assumes: One channel, 32-bit system bus, registers on a plain strobe port.
// Notes: Register offsets are byte addresses of 32-bit words.
package dmamm_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 16;

    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PADDR = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IRQEN = 8'h18;

    // Control register field positions.
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIR = 4;
    localparam int CTRL_WRAP = 5;
    localparam int CTRL_PSTEP = 6;
    localparam int CTRL_MSTEP = 7;
    localparam int CTRL_PWIDTH_LO = 8;
    localparam int CTRL_MWIDTH_LO = 10;
    localparam int CTRL_M2M = 14;
    localparam int CTRL_W = 15;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

    // Status, clear and interrupt enable share this layout.
    localparam int ST_DONE = 0;
    localparam int ST_HALF = 1;
    localparam int ST_W = 2;
    localparam logic [ST_W-1:0] ST_RESET = 2'h0;

    localparam logic [1:0] W_BYTE = 2'h0;
    localparam logic [1:0] W_HALF = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;

    localparam logic [DATA_W-1:0] STEP_BYTE = 32'h00000001;
    localparam logic [DATA_W-1:0] STEP_HALF = 32'h00000002;
    localparam logic [DATA_W-1:0] STEP_WORD = 32'h00000004;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARB,
        ST_READ,
        ST_WRITE,
        ST_NEXT,
        ST_RELEASE
    } dmamm_state_e;

    // Reserved width code 3 is handled as a word.
    function automatic logic [DATA_W-1:0] dmamm_step(input logic [1:0] width);
        logic [DATA_W-1:0] step;
        step = STEP_WORD;
        if (width == W_BYTE) begin
            step = STEP_BYTE;
        end else if (width == W_HALF) begin
            step = STEP_HALF;
        end
        return step;
    endfunction : dmamm_step

endpackage : dmamm_pkg

// >>> core/dmamm_align.sv
// Purpose: Width conversion of one item from source element to destination element.
// Assumes: Read data arrive right-justified on the bus.
// Notes: Narrow results are duplicated over all lanes for slaves that ignore size.
`timescale 1ns/1ps
module dmamm_align (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] src_width,
    input wire logic [1:0] dst_width,
    input wire logic [dmamm_pkg::DATA_W-1:0] rdata,
    output logic [dmamm_pkg::DATA_W-1:0] wdata
);

    logic [dmamm_pkg::DATA_W-1:0] elem;

    always_comb begin
        elem = rdata;
        if (src_width == dmamm_pkg::W_BYTE) begin
            elem = {24'h000000, rdata[7:0]}; // RULE6 RULE7
        end else if (src_width == dmamm_pkg::W_HALF) begin
            elem = {16'h0000, rdata[15:0]}; // RULE9
        end
    end

    always_comb begin
        wdata = elem;
        if (dst_width == dmamm_pkg::W_BYTE) begin
            wdata = {4{elem[7:0]}}; // RULE8 RULE10
        end else if (dst_width == dmamm_pkg::W_HALF) begin
            wdata = {2{elem[15:0]}}; // RULE6 RULE11
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    equal_copy_a: assert property ((src_width == dst_width && src_width == dmamm_pkg::W_HALF)
        |-> wdata[15:0] == rdata[15:0]) else $error("halfword copy altered"); // RULE5
    byte_half_a: assert property ((src_width == dmamm_pkg::W_BYTE && dst_width == dmamm_pkg::W_HALF)
        |-> wdata[15:0] == {8'h00, rdata[7:0]}) else $error("byte not zero-extended"); // RULE6
    byte_word_a: assert property ((src_width == dmamm_pkg::W_BYTE && dst_width == dmamm_pkg::W_WORD)
        |-> wdata == {24'h000000, rdata[7:0]}) else $error("byte to word wrong"); // RULE7
    half_byte_a: assert property ((src_width == dmamm_pkg::W_HALF && dst_width == dmamm_pkg::W_BYTE)
        |-> wdata[7:0] == rdata[7:0]) else $error("half to byte wrong"); // RULE8
    half_word_a: assert property ((src_width == dmamm_pkg::W_HALF && dst_width == dmamm_pkg::W_WORD)
        |-> wdata == {16'h0000, rdata[15:0]}) else $error("half to word wrong"); // RULE9
    word_byte_a: assert property ((src_width == dmamm_pkg::W_WORD && dst_width == dmamm_pkg::W_BYTE)
        |-> wdata[7:0] == rdata[7:0]) else $error("word to byte wrong"); // RULE10
    word_half_a: assert property ((src_width == dmamm_pkg::W_WORD && dst_width == dmamm_pkg::W_HALF)
        |-> wdata[15:0] == rdata[15:0]) else $error("word to half wrong"); // RULE11

endmodule : dmamm_align

// >>> core/dmamm_channel.sv
// Purpose: One DMA channel with software-triggered memory-to-memory mode and width packing.
// Assumes: Bus grant comes from the channel priority arbiter outside this block.
// Notes: An item is always one read then one write; disabling only stops the next item.
`timescale 1ns/1ps
// Summary of operation
// RULE1: With memory-to-memory set, transfers start as soon as enable is set.
// RULE2: Memory-to-memory transfers stop when the remaining count reaches zero.
// RULE3: Software never combines memory-to-memory with wraparound mode.
// RULE4: Each item is one source read then one destination write, width aligned.
// RULE5: Equal widths copy unchanged; addresses step by the element size.
// RULE6: Byte to halfword zero-extends; source steps one, destination two.
// RULE7: Byte to word zero-extends into low byte; destination steps four.
// RULE8: Halfword to byte writes the low byte; steps two and one.
// RULE9: Halfword to word zero-extends into low half; destination steps four.
// RULE10: Word to byte writes the low byte; steps four and one.
// RULE11: Word to halfword writes the low half; steps four and two.
// RULE12: Incrementing sides add one, two or four by their own width.
// RULE13: Software picks peripheral and memory widths in two control fields.
// RULE14: At the end of the count set the done flag, interrupt if enabled.
// RULE15: Memory-to-memory channels request the arbiter continuously until count is zero; here bus_req drops in ST_NEXT and ST_IDLE between items.
module dmamm_channel #(
    parameter int COUNT_W = dmamm_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [dmamm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dmamm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [dmamm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic periph_req,
    output logic periph_ack,
    output logic bus_req,
    input wire logic bus_gnt,
    output logic bus_valid,
    output logic bus_write,
    output logic [1:0] bus_size,
    output logic [dmamm_pkg::DATA_W-1:0] bus_addr,
    output logic [dmamm_pkg::DATA_W-1:0] bus_wdata,
    input wire logic [dmamm_pkg::DATA_W-1:0] bus_rdata,
    input wire logic bus_ready,
    output logic irq
);

    dmamm_pkg::dmamm_state_e state_ff;
    dmamm_pkg::dmamm_state_e nxt_state;
    logic [dmamm_pkg::CTRL_W-1:0] ctrl_ff;
    logic [dmamm_pkg::DATA_W-1:0] base_paddr_ff;
    logic [dmamm_pkg::DATA_W-1:0] base_maddr_ff;
    logic [dmamm_pkg::DATA_W-1:0] cur_paddr_ff;
    logic [dmamm_pkg::DATA_W-1:0] cur_maddr_ff;
    logic [COUNT_W-1:0] base_cnt_ff;
    logic [COUNT_W-1:0] count_ff;
    logic [COUNT_W-1:0] nxt_count;
    logic [dmamm_pkg::ST_W-1:0] status_ff;
    logic [dmamm_pkg::ST_W-1:0] irqen_ff;
    logic [dmamm_pkg::ST_W-1:0] set_ev;
    logic [dmamm_pkg::ST_W-1:0] clr_ev;
    logic [dmamm_pkg::DATA_W-1:0] rdata_ff;
    logic en_q_ff;
    logic bus_write_ff;
    logic [1:0] bus_size_ff;
    logic [dmamm_pkg::DATA_W-1:0] bus_addr_ff;
    logic [dmamm_pkg::DATA_W-1:0] bus_wdata_ff;
    logic [dmamm_pkg::DATA_W-1:0] aligned;
    logic enable;
    logic m2m;
    logic wrap;
    logic dir_mem_src;
    logic [1:0] periph_width_sel;
    logic [1:0] mem_width_sel;
    logic [1:0] src_width;
    logic [1:0] dst_width;
    logic en_rise;
    logic go;
    logic last_item;

    assign enable = ctrl_ff[dmamm_pkg::CTRL_EN];
    assign m2m = ctrl_ff[dmamm_pkg::CTRL_M2M];
    assign wrap = ctrl_ff[dmamm_pkg::CTRL_WRAP];
    assign dir_mem_src = ctrl_ff[dmamm_pkg::CTRL_DIR];
    assign periph_width_sel = ctrl_ff[dmamm_pkg::CTRL_PWIDTH_LO +: 2]; // RULE13
    assign mem_width_sel = ctrl_ff[dmamm_pkg::CTRL_MWIDTH_LO +: 2]; // RULE13
    assign src_width = dir_mem_src ? mem_width_sel : periph_width_sel;
    assign dst_width = dir_mem_src ? periph_width_sel : mem_width_sel;
    assign en_rise = enable && !en_q_ff;
    assign last_item = (count_ff == {{(COUNT_W-1){1'b0}}, 1'b1});
    assign nxt_count = count_ff - {{(COUNT_W-1){1'b0}}, 1'b1};
    // A memory-to-memory channel behaves as if its request were always high.
    assign go = enable && (count_ff != '0) && (m2m || periph_req); // RULE1 RULE2 RULE15

    // Software registers; the count and addresses are frozen while enabled.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= dmamm_pkg::CTRL_RESET;
            base_paddr_ff <= '0;
            base_maddr_ff <= '0;
            irqen_ff <= dmamm_pkg::ST_RESET;
        end else if (reg_write) begin
            if (reg_addr == dmamm_pkg::REG_CTRL) begin
                ctrl_ff <= reg_wdata[dmamm_pkg::CTRL_W-1:0];
            end
            if (reg_addr == dmamm_pkg::REG_PADDR && !enable) begin
                base_paddr_ff <= reg_wdata;
            end
            if (reg_addr == dmamm_pkg::REG_MADDR && !enable) begin
                base_maddr_ff <= reg_wdata;
            end
            if (reg_addr == dmamm_pkg::REG_IRQEN) begin
                irqen_ff <= reg_wdata[dmamm_pkg::ST_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_q_ff <= 1'b0;
        end else begin
            en_q_ff <= enable;
        end
    end

    // Remaining count: software loads it only while disabled.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
            base_cnt_ff <= '0;
        end else if (reg_write && reg_addr == dmamm_pkg::REG_COUNT && !enable) begin
            count_ff <= reg_wdata[COUNT_W-1:0];
            base_cnt_ff <= reg_wdata[COUNT_W-1:0];
        end else if (state_ff == dmamm_pkg::ST_NEXT) begin
            // Wraparound with memory-to-memory would never stop, hence it is not allowed.
            if (last_item && wrap) begin // RULE3
                count_ff <= base_cnt_ff;
            end else begin
                count_ff <= nxt_count; // RULE2
            end
        end
    end

    // Internal current addresses, reloaded from the bases on enable and on wrap.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_paddr_ff <= '0;
            cur_maddr_ff <= '0;
        end else if (en_rise || (state_ff == dmamm_pkg::ST_NEXT && last_item && wrap)) begin
            cur_paddr_ff <= base_paddr_ff;
            cur_maddr_ff <= base_maddr_ff;
        end else if (state_ff == dmamm_pkg::ST_NEXT) begin
            if (ctrl_ff[dmamm_pkg::CTRL_PSTEP]) begin
                cur_paddr_ff <= cur_paddr_ff + dmamm_pkg::dmamm_step(periph_width_sel); // RULE12 RULE5
            end
            if (ctrl_ff[dmamm_pkg::CTRL_MSTEP]) begin
                cur_maddr_ff <= cur_maddr_ff + dmamm_pkg::dmamm_step(mem_width_sel); // RULE12 RULE5
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dmamm_pkg::ST_IDLE: begin
                if (go) begin
                    nxt_state = dmamm_pkg::ST_ARB; // RULE1
                end
            end
            dmamm_pkg::ST_ARB: begin
                if (!go) begin
                    nxt_state = dmamm_pkg::ST_IDLE;
                end else if (bus_gnt) begin
                    nxt_state = dmamm_pkg::ST_READ; // RULE15
                end
            end
            dmamm_pkg::ST_READ: begin
                if (bus_ready) begin
                    nxt_state = dmamm_pkg::ST_WRITE; // RULE4
                end
            end
            dmamm_pkg::ST_WRITE: begin
                if (bus_ready) begin
                    nxt_state = dmamm_pkg::ST_NEXT;
                end
            end
            dmamm_pkg::ST_NEXT: begin
                nxt_state = m2m ? dmamm_pkg::ST_IDLE : dmamm_pkg::ST_RELEASE;
            end
            dmamm_pkg::ST_RELEASE: begin
                if (!periph_req) begin
                    nxt_state = dmamm_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = dmamm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= dmamm_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    dmamm_align u_align (
        .clk(clk),
        .reset_n(reset_n),
        .src_width(src_width),
        .dst_width(dst_width),
        .rdata(bus_rdata),
        .wdata(aligned)
    );

    // Bus address, size and data are set up one phase ahead of each access.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_write_ff <= 1'b0;
            bus_size_ff <= dmamm_pkg::W_BYTE;
            bus_addr_ff <= '0;
            bus_wdata_ff <= '0;
        end else if (state_ff == dmamm_pkg::ST_ARB && bus_gnt && go) begin
            bus_write_ff <= 1'b0;
            bus_size_ff <= src_width;
            bus_addr_ff <= dir_mem_src ? cur_maddr_ff : cur_paddr_ff;
        end else if (state_ff == dmamm_pkg::ST_READ && bus_ready) begin
            bus_write_ff <= 1'b1; // RULE4
            bus_size_ff <= dst_width;
            bus_addr_ff <= dir_mem_src ? cur_paddr_ff : cur_maddr_ff;
            bus_wdata_ff <= aligned; // RULE4
        end
    end

    assign bus_req = (state_ff == dmamm_pkg::ST_ARB) || (state_ff == dmamm_pkg::ST_READ)
        || (state_ff == dmamm_pkg::ST_WRITE);
    assign bus_valid = (state_ff == dmamm_pkg::ST_READ) || (state_ff == dmamm_pkg::ST_WRITE);
    assign bus_write = bus_write_ff;
    assign bus_size = bus_size_ff;
    assign bus_addr = bus_addr_ff;
    assign bus_wdata = bus_wdata_ff;
    assign periph_ack = (state_ff == dmamm_pkg::ST_RELEASE);

    // Event flags: a set in the same cycle as a clear wins.
    always_comb begin
        set_ev = '0;
        if (state_ff == dmamm_pkg::ST_NEXT) begin
            set_ev[dmamm_pkg::ST_DONE] = last_item; // RULE14
            set_ev[dmamm_pkg::ST_HALF] = (nxt_count == (base_cnt_ff >> 1));
        end
        clr_ev = '0;
        if (reg_write && reg_addr == dmamm_pkg::REG_CLEAR) begin
            clr_ev = reg_wdata[dmamm_pkg::ST_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= dmamm_pkg::ST_RESET;
        end else begin
            status_ff <= set_ev | (status_ff & ~clr_ev); // RULE14
        end
    end

    assign irq = |(status_ff & irqen_ff); // RULE14

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                dmamm_pkg::REG_CTRL: rdata_ff <= {17'h00000, ctrl_ff};
                dmamm_pkg::REG_COUNT: rdata_ff <= {{(dmamm_pkg::DATA_W-COUNT_W){1'b0}}, count_ff};
                dmamm_pkg::REG_PADDR: rdata_ff <= base_paddr_ff;
                dmamm_pkg::REG_MADDR: rdata_ff <= base_maddr_ff;
                dmamm_pkg::REG_STATUS: rdata_ff <= {30'h00000000, status_ff};
                dmamm_pkg::REG_IRQEN: rdata_ff <= {30'h00000000, irqen_ff};
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence item_read_s;
        bus_valid && !bus_write && bus_ready;
    endsequence
    sequence item_write_s;
        bus_valid && bus_write && bus_size == $past(dst_width);
    endsequence

    m2m_start_a: assert property (($rose(enable) && m2m && count_ff != '0
        && state_ff == dmamm_pkg::ST_IDLE) |=> bus_req) else $error("m2m did not start"); // RULE1
    zero_stop_a: assert property ((state_ff == dmamm_pkg::ST_IDLE && count_ff == '0)
        |=> !bus_req) else $error("request with zero count"); // RULE2
    read_write_a: assert property (item_read_s |=> item_write_s)
        else $error("write did not follow read"); // RULE4
    periph_step_a: assert property ((state_ff == dmamm_pkg::ST_NEXT && ctrl_ff[dmamm_pkg::CTRL_PSTEP]
        && !last_item) |=> cur_paddr_ff == $past(cur_paddr_ff)
        + dmamm_pkg::dmamm_step($past(periph_width_sel)))
        else $error("peripheral address step wrong"); // RULE12
    mem_hold_a: assert property ((state_ff == dmamm_pkg::ST_NEXT && !ctrl_ff[dmamm_pkg::CTRL_MSTEP]
        && !last_item) |=> $stable(cur_maddr_ff)) else $error("memory address moved"); // RULE12
    done_flag_a: assert property ((state_ff == dmamm_pkg::ST_NEXT && last_item)
        |=> status_ff[dmamm_pkg::ST_DONE] ##0 (irq == irqen_ff[dmamm_pkg::ST_DONE] || irq))
        else $error("done flag not set"); // RULE14
    req_hold_a: assert property ((state_ff == dmamm_pkg::ST_ARB && !bus_gnt && go)
        |=> bus_req) else $error("request dropped before grant"); // RULE15
    m2m_count_a: assert property ((state_ff == dmamm_pkg::ST_NEXT && m2m && !wrap)
        |=> count_ff == $past(count_ff) - 16'h0001 ##1 state_ff != dmamm_pkg::ST_RELEASE)
        else $error("count did not decrement"); // RULE2

endmodule : dmamm_channel

// >>> verification/dmamm_mem_model.sv
// Purpose: Byte memory that grants and answers the channel's system bus accesses.
// Assumes: Read data go back right-justified, as the channel expects.
// Notes: With slow set, each grant or access after the first waits two more cycles.
`timescale 1ns/1ps
module dmamm_mem_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic bus_req,
    output logic bus_gnt,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_ready
);
    logic [7:0] mem [0:127];
    logic [6:0] a;
    logic [31:0] w;
    int n_rd;
    int n_wr;
    int dly;
    assign a = bus_addr[6:0];
    assign w = {mem[a+3], mem[a+2], mem[a+1], mem[a]};
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_gnt <= 1'b0;
            bus_ready <= 1'b0;
            bus_rdata <= 32'h00000000;
            dly <= 0;
        end else begin
            bus_gnt <= 1'b0;
            bus_ready <= 1'b0;
            // Stale read data keep changing so a late sample never passes.
            bus_rdata <= ~bus_rdata;
            if ((bus_req && !bus_valid && !bus_gnt) || (bus_valid && !bus_ready)) begin
                if (dly > 0) begin
                    dly <= dly - 1;
                end else begin
                    dly <= slow ? 2 : 0;
                    bus_gnt <= !bus_valid;
                    bus_ready <= bus_valid;
                    if (bus_valid && !bus_write) begin
                        bus_rdata <= (bus_size == 2'h0) ? {24'h000000, w[7:0]} :
                            (bus_size == 2'h1) ? {16'h0000, w[15:0]} : w;
                    end
                end
            end
            if (bus_valid && bus_ready && bus_write) begin
                mem[a] <= bus_wdata[7:0];
                if (bus_size != 2'h0) begin
                    mem[a+1] <= bus_wdata[15:8];
                end
                if (bus_size == 2'h2) begin
                    mem[a+2] <= bus_wdata[23:16];
                    mem[a+3] <= bus_wdata[31:24];
                end
                n_wr <= n_wr + 1;
            end else if (bus_valid && bus_ready) begin
                n_rd <= n_rd + 1;
            end
        end
    end
endmodule : dmamm_mem_model

// >>> verification/tb_dma_mem_to_mem_width_packing.sv
// Purpose: Self-checking bench for the memory-to-memory channel with width packing.
// Assumes: The memory model grants and answers every access, sometimes late.
// Notes: Only periph_req is tied low, since this mode must run without it.
`timescale 1ns/1ps
module tb_dma_mem_to_mem_width_packing;
    logic clk, reset_n, reg_write, reg_read, irq, slow;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata;
    logic bus_req, bus_gnt, bus_valid, bus_write, bus_ready, periph_ack;
    logic [1:0] bus_size;
    int fails;
    int check_count;
    dmamm_channel i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .periph_req(1'b0), .periph_ack(periph_ack), .bus_req(bus_req),
        .bus_gnt(bus_gnt), .bus_valid(bus_valid), .bus_write(bus_write),
        .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ready(bus_ready), .irq(irq));
    dmamm_mem_model i_mem (.clk(clk), .reset_n(reset_n), .slow(slow), .bus_req(bus_req),
        .bus_gnt(bus_gnt), .bus_valid(bus_valid), .bus_write(bus_write),
        .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ready(bus_ready));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_rd
    task automatic test_reset();
        logic [31:0] d;
        chk("irq", 32'(irq), 32'h0);
        reg_rd(dmamm_pkg::REG_CTRL, d);
        chk("ctrl", d, 32'h0);
        reg_rd(dmamm_pkg::REG_COUNT, d);
        chk("count", d, 32'h0);
        reg_rd(dmamm_pkg::REG_STATUS, d);
        chk("status", d, 32'h0);
        reg_rd(8'h1C, d);
        chk("unmapped", d, 32'h0);
        $display("reset test done");
    endtask : test_reset
    task automatic run_widths(input logic [1:0] sw, input logic [1:0] dw);
        logic [31:0] c, d;
        logic [7:0] exp;
        int ss, ds, n, it;
        ss = 1 << sw;
        ds = 1 << dw;
        for (int k = 0; k < 16; k++) begin
            i_mem.mem[8'h40+k] = 8'h55;
        end
        i_mem.n_rd = 0;
        i_mem.n_wr = 0;
        c = 32'h0;
        c[dmamm_pkg::CTRL_EN] = 1'b1;
        c[dmamm_pkg::CTRL_PSTEP] = 1'b1;
        c[dmamm_pkg::CTRL_MSTEP] = 1'b1;
        c[dmamm_pkg::CTRL_PWIDTH_LO+:2] = sw;
        c[dmamm_pkg::CTRL_MWIDTH_LO+:2] = dw;
        c[dmamm_pkg::CTRL_M2M] = 1'b1;
        reg_wr(dmamm_pkg::REG_CTRL, 32'h0);
        reg_wr(dmamm_pkg::REG_COUNT, 32'h4);
        reg_wr(dmamm_pkg::REG_PADDR, 32'h0);
        reg_wr(dmamm_pkg::REG_MADDR, 32'h40);
        reg_wr(dmamm_pkg::REG_CLEAR, 32'h3);
        reg_wr(dmamm_pkg::REG_IRQEN, 32'h1);
        // Wraparound stays clear; both width fields are set independently.
        reg_wr(dmamm_pkg::REG_CTRL, c);
        n = 0;
        while (bus_req !== 1'b1 && n < 4) begin
            @(posedge clk);
            n++;
        end
        chk("start", 32'(n < 4), 32'h1);
        if (n == 4) begin
            report_and_stop();
        end
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            chk("finish", 32'h0, 32'h1);
            report_and_stop();
        end
        reg_rd(dmamm_pkg::REG_COUNT, d);
        chk("count", d, 32'h0);
        reg_rd(dmamm_pkg::REG_STATUS, d);
        chk("status", d, 32'h3);
        n = 0;
        repeat (10) begin
            @(posedge clk);
            n += int'(bus_req !== 1'b0);
        end
        chk("idle", 32'(n), 32'h0);
        chk("reads", 32'(i_mem.n_rd), 32'h4);
        chk("writes", 32'(i_mem.n_wr), 32'h4);
        for (int b = 0; b < 16; b++) begin
            it = b / ds;
            exp = (it >= 4) ? 8'h55 : ((b % ds) < ss) ? 8'(8'hB0 + it * ss + b % ds) : 8'h00;
            chk("dst byte", 32'(i_mem.mem[8'h40+b]), 32'(exp));
        end
        $display("widths %0d to %0d done", ss, ds);
    endtask : run_widths
    task automatic test_fixed_dst();
        logic [31:0] c;
        int n, acks;
        c = 32'h0;
        c[dmamm_pkg::CTRL_EN] = 1'b1;
        c[dmamm_pkg::CTRL_PSTEP] = 1'b1;
        c[dmamm_pkg::CTRL_M2M] = 1'b1;
        i_mem.n_wr = 0;
        reg_wr(dmamm_pkg::REG_CTRL, 32'h0);
        reg_wr(dmamm_pkg::REG_COUNT, 32'h2);
        reg_wr(dmamm_pkg::REG_MADDR, 32'h50);
        // The memory side does not step, so both bytes land on one address.
        reg_wr(dmamm_pkg::REG_CTRL, c);
        n = 0;
        acks = 0;
        while (i_mem.n_wr < 2 && n < 100) begin
            @(posedge clk);
            acks += int'(periph_ack !== 1'b0);
            n++;
        end
        repeat (4) @(posedge clk);
        chk("fixed writes", 32'(i_mem.n_wr), 32'h2);
        if (n == 100) begin
            report_and_stop();
        end
        chk("no ack", 32'(acks), 32'h0);
        chk("fixed dst", 32'(i_mem.mem[8'h50]), 32'hB1);
        chk("next byte", 32'(i_mem.mem[8'h51]), 32'h01);
        reg_wr(dmamm_pkg::REG_CTRL, 32'h0);
        $display("fixed address test done");
    endtask : test_fixed_dst
    task automatic test_irq();
        logic [31:0] d;
        reg_wr(dmamm_pkg::REG_CLEAR, 32'h1);
        chk("irq masked", 32'(irq), 32'h0);
        reg_wr(dmamm_pkg::REG_IRQEN, 32'h2);
        chk("irq half", 32'(irq), 32'h1);
        reg_wr(dmamm_pkg::REG_CLEAR, 32'h2);
        chk("irq cleared", 32'(irq), 32'h0);
        reg_rd(dmamm_pkg::REG_STATUS, d);
        chk("status", d, 32'h0);
        $display("interrupt test done");
    endtask : test_irq
    task automatic test_zero();
        logic [31:0] d;
        int n;
        reg_wr(dmamm_pkg::REG_CTRL, 32'h0);
        reg_wr(dmamm_pkg::REG_COUNT, 32'h0);
        reg_wr(dmamm_pkg::REG_CTRL, 32'h4001);
        reg_wr(dmamm_pkg::REG_COUNT, 32'h5);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            n += int'(bus_req !== 1'b0);
        end
        chk("no transfer", 32'(n), 32'h0);
        reg_rd(dmamm_pkg::REG_COUNT, d);
        chk("count kept", d, 32'h0);
        reg_rd(dmamm_pkg::REG_STATUS, d);
        chk("status", d, 32'h0);
        reg_wr(dmamm_pkg::REG_CTRL, 32'h0);
        $display("zero count test done");
    endtask : test_zero
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        slow = 1'b0;
        fails = 0;
        check_count = 0;
        for (int k = 0; k < 128; k++) begin
            i_mem.mem[k] = 8'(8'hB0 + k);
        end
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        test_reset();
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 3; d++) begin
                slow = 1'((s + d) % 2);
                run_widths(2'(s), 2'(d));
            end
        end
        test_fixed_dst();
        test_irq();
        test_zero();
        report_and_stop();
    end
endmodule : tb_dma_mem_to_mem_width_packing
